// ---- common/sar_pkg.sv ----
// Package with constants and types shared by the converter readout block.
package sar_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int RESULT_W = 16;
  localparam int CODE_W = 18;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SAFE_FAST_NS = 190;
  localparam int SAFE_NORMAL_NS = 290;
  localparam int CONV_TIME_NS = 700;
  // A longest time rounds down, but never below one cycle.
  localparam int SAFE_FAST_RAW = SAFE_FAST_NS / CLK_PERIOD_NS;
  localparam int SAFE_NORMAL_RAW = SAFE_NORMAL_NS / CLK_PERIOD_NS;
  localparam logic [7:0] SAFE_FAST_CYC = 8'((SAFE_FAST_RAW < 1) ? 1 : SAFE_FAST_RAW);
  localparam logic [7:0] SAFE_NORMAL_CYC = 8'((SAFE_NORMAL_RAW < 1) ? 1 : SAFE_NORMAL_RAW);
  // The conversion time is a least time and rounds up.
  localparam logic [7:0] CONV_CYC = 8'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] ONE_BIT = 5'h01;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam int CFG_FOUR_WIRE = 0;
  localparam int CFG_LEN_LSB = 8;
  localparam int ST_LATE = 0;
  localparam int ST_INVALID = 1;
  localparam int ST_CONV = 2;
  localparam int ST_CHAIN = 3;
  localparam int ST_READING = 4;
  localparam int ST_REF_ON = 5;
  localparam int ST_POWER = 6;
  localparam logic [RESULT_W-1:0] RESULT_MAX = 16'hFFFF;
  localparam logic [RESULT_W-1:0] RESULT_MIN = 16'h0000;

  // ----------------------------------------------------------------
  // Synchroniser lanes for the pins
  // ----------------------------------------------------------------
  localparam int PIN_N = 5;
  localparam int PIN_START = 0;
  localparam int PIN_DIN = 1;
  localparam int PIN_SCK = 2;
  localparam int PIN_FAST = 3;
  localparam int PIN_REFOFF = 4;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CV_ACQ = 2'b00, CV_CONV = 2'b01} sar_conv_st_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b00, RD_START = 2'b01, RD_SHIFT = 2'b11} sar_rd_st_t;

endpackage

// ---- hdl/sar_sync.sv ----
// Two flip-flop synchroniser for a group of asynchronous pins.
module sar_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Pins in, synchronised levels out.
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] pin_sync
);

  // ----------------------------------------------------------------
  // One pair of flip-flops per lane
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_lane
      logic meta_reg;
      logic sync_reg;
      // The first stage feeds only the second stage.
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else
        begin
          meta_reg <= pin_async[i];
          sync_reg <= meta_reg;
        end
      end
      assign pin_sync[i] = sync_reg;
    end
  endgenerate

endmodule

// ---- hdl/sar_readout.sv ----
// Readout sequencer and interface control of a 16-bit converter.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
module sar_readout #(
  parameter logic [7:0] CONV_LEN = sar_pkg::CONV_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Pins from the host.
  input wire logic conversion_start,
  input wire logic serial_data_in,
  input wire logic serial_clock,
  input wire logic fast_mode_select,
  input wire logic reference_powerdown,
  // Serial output pin.
  output logic serial_data_out,
  output logic serial_data_out_oe,
  // Raw signed code from the approximation core.
  input wire logic [sar_pkg::CODE_W-1:0] conv_code_in,
  // Analog control outputs.
  output logic reference_enable,
  output logic core_power_on,
  output logic converting,
  // Register port.
  input wire logic [sar_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sar_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sar_pkg::DATA_W-1:0] reg_rdata
);

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [sar_pkg::PIN_N-1:0] pins_s;
  logic [sar_pkg::PIN_N-1:0] pins_d_reg;
  logic start_s, din_s, sck_s, fast_s, refoff_s, start_d, din_d, sck_d, fast_d;

  sar_sync #(.W(sar_pkg::PIN_N)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_async({reference_powerdown, fast_mode_select, serial_clock, serial_data_in,
                conversion_start}),
    .pin_sync(pins_s)
  );

  // Delayed copies of the synchronised pins give edges and pre-edge levels.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pins_d_reg <= '0;
    else
      pins_d_reg <= pins_s;
  end

  assign start_s = pins_s[sar_pkg::PIN_START];
  assign din_s = pins_s[sar_pkg::PIN_DIN];
  assign sck_s = pins_s[sar_pkg::PIN_SCK];
  assign fast_s = pins_s[sar_pkg::PIN_FAST];
  assign refoff_s = pins_s[sar_pkg::PIN_REFOFF];
  assign start_d = pins_d_reg[sar_pkg::PIN_START];
  assign din_d = pins_d_reg[sar_pkg::PIN_DIN];
  assign sck_d = pins_d_reg[sar_pkg::PIN_SCK];
  assign fast_d = pins_d_reg[sar_pkg::PIN_FAST];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sar_pkg::sar_conv_st_t cv_reg, cv_next;
  sar_pkg::sar_rd_st_t rd_reg, rd_next;
  logic [7:0] cnt_reg, cnt_next;
  logic cs_mode_reg, cs_mode_next;
  logic [sar_pkg::RESULT_W-1:0] result_reg, result_next;
  logic [sar_pkg::RESULT_W-1:0] shift_reg, shift_next;
  logic [4:0] bits_reg, bits_next;
  logic dout_reg, dout_next, oe_reg, oe_next, sel_d_reg;
  logic late_reg, late_next, pend_inv_reg, pend_inv_next, invalid_reg, invalid_next;
  logic four_wire_reg, four_wire_next;
  logic [7:0] len_reg, len_next;
  logic ref_reg, power_reg, power_next, conv_out_reg;
  logic [sar_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic start_rise, sck_fall, fast_rise, conv_start, conv_done, select, sel_rise, busy_cond;
  logic [7:0] safe_cyc;
  logic [sar_pkg::RESULT_W-1:0] sat_code;

  // Qualified events.
  assign start_rise = start_s && !start_d;
  assign sck_fall = sck_d && !sck_s;
  assign fast_rise = fast_s && !fast_d;
  assign conv_start = start_rise && (cv_reg == sar_pkg::CV_ACQ);
  assign conv_done = (cv_reg == sar_pkg::CV_CONV) &&
                     ({1'b0, cnt_reg} + 9'h001 >= {1'b0, len_reg});
  // Read select: start line low, plus data-in low in four-wire use.
  assign select = !start_s && (!four_wire_reg || !din_s);
  assign sel_rise = select && !sel_d_reg;
  assign busy_cond = cs_mode_reg && !fast_s && (!start_s || !din_s) && select;
  assign safe_cyc = fast_s ? sar_pkg::SAFE_FAST_CYC : sar_pkg::SAFE_NORMAL_CYC;
  // Straight binary with clamping of out-of-range codes.
  assign sat_code = conv_code_in[sar_pkg::CODE_W-1] ? sar_pkg::RESULT_MIN :
                    conv_code_in[sar_pkg::CODE_W-2] ? sar_pkg::RESULT_MAX :
                    conv_code_in[sar_pkg::RESULT_W-1:0];

  // ----------------------------------------------------------------
  // Conversion sequencing, mode capture and result holding
  // ----------------------------------------------------------------
  always_comb
  begin
    cv_next = cv_reg;
    cnt_next = cnt_reg;
    cs_mode_next = cs_mode_reg;
    result_next = result_reg;
    pend_inv_next = pend_inv_reg || fast_rise;
    invalid_next = invalid_reg;
    case (cv_reg)
      sar_pkg::CV_ACQ:
      begin
        if (conv_start)
        begin
          cv_next = sar_pkg::CV_CONV;
          cnt_next = 8'h00;
          // Outside fast mode, the data-in level from before the edge decides, so a tied line gives chain.
          cs_mode_next = din_d || fast_s;
        end
      end
      sar_pkg::CV_CONV:
      begin
        // The start line is not looked at until the count expires.
        cnt_next = cnt_reg + 8'h01;
        if (conv_done)
        begin
          cv_next = sar_pkg::CV_ACQ;
          result_next = sat_code;
          invalid_next = pend_inv_reg;
          pend_inv_next = fast_rise;
        end
      end
      default:
        cv_next = sar_pkg::CV_ACQ;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cv_reg <= sar_pkg::CV_ACQ;
      cnt_reg <= 8'h00;
      cs_mode_reg <= 1'b1;
      result_reg <= sar_pkg::RESULT_MIN;
      pend_inv_reg <= 1'b0;
      invalid_reg <= 1'b0;
    end
    else
    begin
      cv_reg <= cv_next;
      cnt_reg <= cnt_next;
      cs_mode_reg <= cs_mode_next;
      result_reg <= result_next;
      pend_inv_reg <= pend_inv_next;
      invalid_reg <= invalid_next;
    end
  end

  // ----------------------------------------------------------------
  // Serial readout shifter
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_next = rd_reg;
    shift_next = shift_reg;
    bits_next = bits_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    case (rd_reg)
      sar_pkg::RD_IDLE:
      begin
        if (conv_done && busy_cond)
        begin
          // Output turns on with a low start bit ahead of the fresh result.
          rd_next = sar_pkg::RD_START;
          shift_next = sat_code;
          dout_next = 1'b0;
          oe_next = 1'b1;
        end
        else if (sel_rise)
        begin
          // Held result is the previous conversion's, in any phase.
          rd_next = sar_pkg::RD_SHIFT;
          shift_next = result_reg;
          bits_next = sar_pkg::WORD_BITS;
          dout_next = result_reg[sar_pkg::RESULT_W-1];
          oe_next = 1'b1;
        end
      end
      sar_pkg::RD_START:
      begin
        if (!select)
        begin
          rd_next = sar_pkg::RD_IDLE;
          oe_next = 1'b0;
        end
        else if (sck_fall)
        begin
          rd_next = sar_pkg::RD_SHIFT;
          bits_next = sar_pkg::WORD_BITS;
          dout_next = shift_reg[sar_pkg::RESULT_W-1];
        end
      end
      sar_pkg::RD_SHIFT:
      begin
        if (!select)
        begin
          // Deselect, including start line going high, releases at once.
          rd_next = sar_pkg::RD_IDLE;
          oe_next = 1'b0;
        end
        else if (sck_fall)
        begin
          if (bits_reg == sar_pkg::ONE_BIT)
          begin
            rd_next = sar_pkg::RD_IDLE;
            oe_next = 1'b0;
          end
          else
          begin
            // In chain mode data-in fills the vacated low bit.
            shift_next = {shift_reg[sar_pkg::RESULT_W-2:0], !cs_mode_reg && din_s};
            dout_next = shift_reg[sar_pkg::RESULT_W-2];
            bits_next = bits_reg - sar_pkg::ONE_BIT;
          end
        end
      end
      default:
      begin
        rd_next = sar_pkg::RD_IDLE;
        oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rd_reg <= sar_pkg::RD_IDLE;
      shift_reg <= sar_pkg::RESULT_MIN;
      bits_reg <= 5'h00;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
      sel_d_reg <= 1'b1; // Idle select level, so no read starts on reset release.
    end
    else
    begin
      rd_reg <= rd_next;
      shift_reg <= shift_next;
      bits_reg <= bits_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      sel_d_reg <= select;
    end
  end

  // ----------------------------------------------------------------
  // Registers, late-activity flag and analog controls
  // ----------------------------------------------------------------
  always_comb
  begin
    four_wire_next = four_wire_reg;
    len_next = len_reg;
    late_next = late_reg;
    rdata_next = '0;
    if (reg_wr && reg_addr == sar_pkg::REG_CONFIG)
    begin
      four_wire_next = reg_wdata[sar_pkg::CFG_FOUR_WIRE];
      len_next = reg_wdata[sar_pkg::CFG_LEN_LSB +: 8];
    end
    // Writing one clears; a clock edge in the same cycle still sets.
    if (reg_wr && reg_addr == sar_pkg::REG_STATUS && reg_wdata[sar_pkg::ST_LATE])
      late_next = 1'b0;
    if (sck_fall && cv_reg == sar_pkg::CV_CONV && cnt_reg >= safe_cyc)
      late_next = 1'b1;
    if (reg_rd)
    begin
      case (reg_addr)
        sar_pkg::REG_CONFIG:
        begin
          rdata_next[sar_pkg::CFG_FOUR_WIRE] = four_wire_reg;
          rdata_next[sar_pkg::CFG_LEN_LSB +: 8] = len_reg;
        end
        sar_pkg::REG_STATUS:
        begin
          rdata_next[sar_pkg::ST_LATE] = late_reg;
          rdata_next[sar_pkg::ST_INVALID] = invalid_reg;
          rdata_next[sar_pkg::ST_CONV] = cv_reg == sar_pkg::CV_CONV;
          rdata_next[sar_pkg::ST_CHAIN] = !cs_mode_reg;
          rdata_next[sar_pkg::ST_READING] = oe_reg;
          rdata_next[sar_pkg::ST_REF_ON] = ref_reg;
          rdata_next[sar_pkg::ST_POWER] = power_reg;
        end
        sar_pkg::REG_RESULT:
          rdata_next[sar_pkg::RESULT_W-1:0] = result_reg;
        default:
          rdata_next = '0;
      endcase
    end
    // Core stays up in fast mode, otherwise only while converting.
    power_next = (cv_next == sar_pkg::CV_CONV) || fast_s;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      four_wire_reg <= 1'b0;
      len_reg <= CONV_LEN;
      late_reg <= 1'b0;
      rdata_reg <= '0;
      ref_reg <= 1'b0;
      power_reg <= 1'b0;
      conv_out_reg <= 1'b0;
    end
    else
    begin
      four_wire_reg <= four_wire_next;
      len_reg <= len_next;
      late_reg <= late_next;
      rdata_reg <= rdata_next;
      ref_reg <= !refoff_s;
      power_reg <= power_next;
      conv_out_reg <= cv_next == sar_pkg::CV_CONV;
    end
  end

  assign serial_data_out = dout_reg;
  assign serial_data_out_oe = oe_reg;
  assign reference_enable = ref_reg;
  assign core_power_on = power_reg;
  assign converting = conv_out_reg;
  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_start_edge;
    conv_start && !fast_s;
  endsequence

  property p_mode_pick;
    @(posedge clk_sys) disable iff (rst) s_start_edge |=> cs_mode_reg == $past(din_d);
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("mode not taken from data-in");

  property p_chain_fast;
    @(posedge clk_sys) disable iff (rst) conv_start && fast_s |=> cs_mode_reg;
  endproperty
  a_chain_fast: assert property (p_chain_fast) else $error("chain chosen in fast mode");

  property p_tied;
    @(posedge clk_sys) disable iff (rst) s_start_edge ##0 (din_s && !din_d) |=> !cs_mode_reg;
  endproperty
  a_tied: assert property (p_tied) else $error("tied lines did not give chain");

  property p_runs;
    @(posedge clk_sys) disable iff (rst)
      cv_reg == sar_pkg::CV_CONV && !conv_done |=> cv_reg == sar_pkg::CV_CONV;
  endproperty
  a_runs: assert property (p_runs) else $error("conversion ended early");

  property p_busy;
    @(posedge clk_sys) disable iff (rst)
      rd_reg == sar_pkg::RD_IDLE && conv_done && !busy_cond |=> rd_reg != sar_pkg::RD_START;
  endproperty
  a_busy: assert property (p_busy) else $error("start bit without its condition");

  property p_release;
    @(posedge clk_sys) disable iff (rst)
      rd_reg == sar_pkg::RD_SHIFT && bits_reg == sar_pkg::ONE_BIT && sck_fall |=> !oe_reg;
  endproperty
  a_release: assert property (p_release) else $error("output held after last bit");

  property p_high_quiet;
    @(posedge clk_sys) disable iff (rst) start_s |=> !oe_reg;
  endproperty
  a_high_quiet: assert property (p_high_quiet) else $error("driving with start high");

  property p_clamp;
    @(posedge clk_sys) disable iff (rst)
      conv_done && conv_code_in[sar_pkg::CODE_W-1] |=> result_reg == sar_pkg::RESULT_MIN;
  endproperty
  a_clamp: assert property (p_clamp) else $error("negative code not clamped");

  property p_prev;
    @(posedge clk_sys) disable iff (rst)
      rd_reg == sar_pkg::RD_IDLE && sel_rise && !(conv_done && busy_cond)
      |=> oe_reg && dout_reg == $past(result_reg[sar_pkg::RESULT_W-1]);
  endproperty
  a_prev: assert property (p_prev) else $error("read did not show held result");

  property p_power;
    @(posedge clk_sys) disable iff (rst)
      cv_reg == sar_pkg::CV_ACQ && !conv_start && !fast_s |=> !power_reg;
  endproperty
  a_power: assert property (p_power) else $error("core left on between conversions");

  property p_ref;
    @(posedge clk_sys) disable iff (rst) refoff_s |=> !reference_enable;
  endproperty
  a_ref: assert property (p_ref) else $error("reference on while powered down");

endmodule

// ---- verif/sar_host_model.sv ----
// Host model that drives the converter pins and shifts the result in.
module sar_host_model (
  // Clock.
  input wire logic clk_sys,
  // Converter pins.
  output logic conversion_start,
  output logic serial_data_in,
  output logic serial_clock,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [16:0] rx_word;
  logic line_last;
  int rx_oe;

  // Pins rest idle, with the serial clock standing still.
  initial
  begin
    conversion_start = 1'b0;
    serial_data_in = 1'b1;
    serial_clock = 1'b0;
    line_last = 1'b0;
  end

  // Moves start and data-in together just after an edge.
  task automatic pins(input logic c, input logic d);
    @(posedge clk_sys);
    conversion_start <= c;
    serial_data_in <= d;
  endtask

  // Clocks n bits at 800 ns a period, sampling before each rise.
  task automatic burst(input int n);
    rx_oe = 0;
    for (int i = 0; i < n; i++)
    begin
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      // A released line reads back as the inverse of its last level.
      line_last = serial_data_out_oe ? serial_data_out : ~line_last;
      rx_word = {rx_word[15:0], line_last};
      rx_oe += int'(serial_data_out_oe);
      @(posedge clk_sys);
      serial_clock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      serial_clock <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

// ---- verif/sar_readout_tb.sv ----
// Self-checking bench for the converter readout block.
module sar_readout_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] LEN = 8'h07;
  logic clk_sys, rst, fast_mode_select, reference_powerdown, reg_wr, reg_rd;
  logic serial_data_out, serial_data_out_oe, reference_enable, core_power_on, converting;
  logic [sar_pkg::CODE_W-1:0] conv_code_in;
  logic [sar_pkg::ADDR_W-1:0] reg_addr;
  logic [sar_pkg::DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
  wire logic conversion_start, serial_data_in, serial_clock;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  logic [17:0] codes [3] = '{18'h0A5C3, 18'h12345, 18'h28001};
  logic [15:0] exps [3] = '{16'hA5C3, 16'hFFFF, 16'h0000};

  // Device and host.
  sar_readout #(.CONV_LEN(LEN)) dut (.clk_sys, .rst, .conversion_start, .serial_data_in,
    .serial_clock, .fast_mode_select, .reference_powerdown, .serial_data_out,
    .serial_data_out_oe, .conv_code_in, .reference_enable, .core_power_on, .converting,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  sar_host_model host (.clk_sys, .conversion_start, .serial_data_in, .serial_clock,
    .serial_data_out, .serial_data_out_oe);

  // 10 MHz system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Cuts a hung run short.
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_fail++;
      close_out();
    end
  end

  // Counts a comparison and passes its outcome on.
  function automatic bit bad(input bit m);
    tests_run++;
    return m;
  endfunction

  // Reports one mismatch.
  task automatic fail(input string m);
    n_fail++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Register port write and read.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rd_val = reg_rdata;
  endtask

  // Waits for a conversion and counts its cycles.
  task automatic wait_conv(output int len);
    int k;
    @(negedge clk_sys);
    for (k = 0; k < 20 && converting !== 1'b1; k++) @(negedge clk_sys);
    for (len = 0; len < 40 && converting === 1'b1; len++) @(negedge clk_sys);
    if (k == 20) fail("no conversion");
  endtask

  // Reset value of the configuration and an unmapped place.
  task automatic t_regs();
    rd(sar_pkg::REG_CONFIG);
    if (bad(rd_val[15:8] !== LEN || rd_val[0] !== 1'b0)) fail("config reset");
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC);
    if (bad(rd_val !== 32'h00000000)) fail("unmapped read");
  endtask

  // Reference power-down pin both ways.
  task automatic t_ref();
    @(posedge clk_sys);
    reference_powerdown <= 1'b1;
    repeat (5) @(negedge clk_sys);
    if (bad(reference_enable !== 1'b0)) fail("reference on");
    @(posedge clk_sys);
    reference_powerdown <= 1'b0;
    repeat (5) @(negedge clk_sys);
    if (bad(reference_enable !== 1'b1)) fail("reference off");
  endtask

  // Select mode without start bit, read in acquisition.
  task automatic t_plain(input int i);
    @(posedge clk_sys);
    conv_code_in <= codes[i];
    host.pins(1'b1, 1'b1);
    wait_conv(n);
    if (bad(serial_data_out_oe !== 1'b0)) fail("driven while start high");
    rd(sar_pkg::REG_STATUS);
    if (bad(rd_val[sar_pkg::ST_CHAIN] !== 1'b0)) fail("chain with data-in high");
    if (bad(core_power_on !== 1'b0)) fail("core on in acquisition");
    host.pins(1'b0, 1'b1);
    host.burst(16);
    if (bad(host.rx_word[15:0] !== exps[i])) fail("serial word");
    if (bad(host.rx_oe !== 16)) fail("output not driven");
    if (bad(serial_data_out_oe !== 1'b0)) fail("not released");
    rd(sar_pkg::REG_RESULT);
    if (bad(rd_val[15:0] !== exps[i])) fail("held result");
  endtask

  // Start line low at conversion end asks for the start bit.
  task automatic t_busy();
    @(posedge clk_sys);
    conv_code_in <= 18'h0BEEF;
    host.pins(1'b1, 1'b1);
    // An earlier fall would open a plain read, which blocks the start bit.
    fork
      wait_conv(n);
      begin
        repeat (int'(LEN) - 1) @(posedge clk_sys);
        host.pins(1'b0, 1'b1);
      end
    join
    if (bad(n !== int'(LEN))) fail("conversion length");
    host.burst(17);
    if (bad(host.rx_word !== {1'b0, 16'hBEEF})) fail("start bit word");
    if (bad(host.rx_oe !== 17)) fail("start bit length");
  endtask

  // Tied start and data-in pick chain; fast mode forces select mode.
  task automatic t_modes();
    host.pins(1'b0, 1'b0);
    host.pins(1'b1, 1'b1);
    wait_conv(n);
    rd(sar_pkg::REG_STATUS);
    if (bad(rd_val[sar_pkg::ST_CHAIN] !== 1'b1)) fail("tied lines");
    @(posedge clk_sys);
    fast_mode_select <= 1'b1;
    host.pins(1'b0, 1'b0);
    host.pins(1'b1, 1'b0);
    wait_conv(n);
    rd(sar_pkg::REG_STATUS);
    if (bad(rd_val[sar_pkg::ST_CHAIN] !== 1'b0)) fail("chain in fast");
    if (bad(rd_val[sar_pkg::ST_INVALID] !== 1'b1)) fail("invalid flag");
    if (bad(core_power_on !== 1'b1)) fail("core off in fast");
    @(posedge clk_sys);
    fast_mode_select <= 1'b0;
  endtask

  // Four-wire arrangement: data-in low selects the read.
  task automatic t_four();
    wr(sar_pkg::REG_CONFIG, {16'h0000, LEN, 8'h01});
    host.pins(1'b0, 1'b1);
    repeat (5) @(negedge clk_sys);
    if (bad(serial_data_out_oe !== 1'b0)) fail("driven unselected");
    host.pins(1'b0, 1'b0);
    repeat (5) @(negedge clk_sys);
    if (bad(serial_data_out_oe !== 1'b1)) fail("not driven");
    host.pins(1'b1, 1'b1);
    wait_conv(n);
    wr(sar_pkg::REG_CONFIG, {16'h0000, LEN, 8'h00});
  endtask

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    fast_mode_select = 1'b0;
    reference_powerdown = 1'b0;
    conv_code_in = 18'h00000;
    reg_addr = 4'h0;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_ref();
    for (int i = 0; i < 3; i++) t_plain(i);
    t_busy();
    t_modes();
    t_four();
    close_out();
  end
endmodule
